// >>> hw/ises_consts.svh
// bit positions, reset values, implemented-bit masks and error code ranges for the status bank
`ifndef ISES_CONSTS_SVH
`define ISES_CONSTS_SVH

// standard event latch bit positions
`define ISES_LAT_OPC        0
`define ISES_LAT_QUERY_ERR  2
`define ISES_LAT_DEV_ERR    3
`define ISES_LAT_EXEC_ERR   4
`define ISES_LAT_CMD_ERR    5
`define ISES_LAT_PWR_ON     7

// reset values
`define ISES_LAT_RST        8'h80
`define ISES_MSK_RST        8'h00
`define ISES_ENA_RST        16'h0000

// questionable bit positions
`define ISES_QUES_POWER     3
`define ISES_QUES_FREQ      5
`define ISES_QUES_LIMIT     9
`define ISES_QFREQ_EXTREF   8

// implemented bits per 16-bit register, bit 15 never set
`define ISES_OPER_MASK      16'h0000
`define ISES_QUES_MASK      16'h0228
`define ISES_QFREQ_MASK     16'h0100

// status byte summary positions
`define ISES_STB_QUES       3
`define ISES_STB_ESB        5
`define ISES_STB_OPER       7

// error code ranges, two's complement 16 bit
`define ISES_CMD_HI         16'hff9c
`define ISES_CMD_LO         16'hff39
`define ISES_EXEC_HI        16'hff38
`define ISES_EXEC_LO        16'hfed5
`define ISES_DEV_HI         16'hfed4
`define ISES_DEV_LO         16'hfe71

`endif

// >>> hw/ises_pkg.sv
// types shared by the status and event register bank
package ises_pkg;

	// register part selected by a status query or write
	typedef enum logic [3:0] {
		ISES_SEL_LAT       = 4'h0,
		ISES_SEL_MSK       = 4'h1,
		ISES_SEL_OPER_COND = 4'h2,
		ISES_SEL_OPER_EVT  = 4'h3,
		ISES_SEL_OPER_ENA  = 4'h4,
		ISES_SEL_QUES_COND = 4'h5,
		ISES_SEL_QUES_EVT  = 4'h6,
		ISES_SEL_QUES_ENA  = 4'h7,
		ISES_SEL_QFRQ_COND = 4'h8,
		ISES_SEL_QFRQ_EVT  = 4'h9,
		ISES_SEL_QFRQ_ENA  = 4'ha
	} ises_sel_e;

	typedef struct packed {
		logic        valid;
		logic        write;
		ises_sel_e   sel;
		logic [15:0] wdata;
	} ises_cmd_s;

	typedef struct packed {
		logic        valid;
		logic [15:0] data;
	} ises_rsp_s;

	// instrument-side event and condition sources
	typedef struct packed {
		logic        opc_req;
		logic        ops_busy;
		logic        query_sent;
		logic        resp_read;
		logic        new_cmd;
		logic        dev_err;
		logic        exec_err;
		logic        cmd_err;
		logic [15:0] err_detail;
		logic        power_bad;
		logic        freq_bad;
		logic        limit_fail;
		logic        ext_ref;
	} ises_src_s;

	typedef struct packed {
		logic        push;
		logic [15:0] code;
	} ises_err_s;

	typedef struct packed {
		logic oper_sum;
		logic esb;
		logic ques_sum;
	} ises_sum_s;

	// one 16-bit condition/event/enable register
	typedef struct packed {
		logic [15:0] cond_prev;
		logic [15:0] evt;
		logic [15:0] ena;
	} ises_evreg_s;

	// main bank state
	typedef struct packed {
		logic [7:0]  lat;
		logic [7:0]  msk;
		logic        opc_wait;
		logic        resp_pend;
		ises_rsp_s   rsp;
		ises_err_s   err;
	} ises_state_s;

endpackage

// >>> hw/ises_evreg.sv
// one 16-bit status register: condition, rising-edge event latch, enable, summary
`timescale 1ns/100ps
`default_nettype none
`include "ises_consts.svh"

module ises_evreg
	import ises_pkg::*;
#(
	parameter logic [15:0] VALID_MASK = 16'h0000
) (
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	input  wire logic [15:0] cond_in,
	input  wire logic        evt_clr,
	input  wire logic        ena_we,
	input  wire logic [15:0] ena_wdata,
	output logic [15:0]      cond_out,
	output logic [15:0]      evt_out,
	output logic [15:0]      ena_out,
	output logic             summary
);

	ises_evreg_s st_q;
	ises_evreg_s st_d;
	logic [15:0] cond_m;

	// unassigned bits and bit 15 are masked off at the source
	assign cond_m = cond_in & VALID_MASK;

	// rising edge sets, read clears; a set in the clearing cycle survives
	always_comb begin
		st_d           = st_q;
		st_d.cond_prev = cond_m;
		st_d.evt       = (st_q.evt & ~{16{evt_clr}}) | (cond_m & ~st_q.cond_prev);
		if (ena_we) begin
			st_d.ena = ena_wdata & 16'h7fff;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			st_q <= '{cond_prev: 16'h0000, evt: 16'h0000, ena: `ISES_ENA_RST};
		end else begin
			st_q <= st_d;
		end
	end

	assign cond_out = cond_m;
	assign evt_out  = st_q.evt;
	assign ena_out  = st_q.ena;
	assign summary  = |(st_q.evt & st_q.ena);

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	// something latched and no read in this cycle
	sequence s_evt_kept;
		evt_out != 16'h0000 && !evt_clr;
	endsequence

	chk_evt_rise_latch: assert property (
		(cond_m != 16'h0000 && (cond_m & ~st_q.cond_prev) != 16'h0000)
		|=> ((evt_out & $past(cond_m & ~st_q.cond_prev)) == $past(cond_m & ~st_q.cond_prev)))
		else $error("event bit not latched on condition rise");
	chk_evt_read_clr: assert property (
		evt_clr && ((cond_m & ~st_q.cond_prev) == 16'h0000) |=> evt_out == 16'h0000)
		else $error("event part not cleared by read");
	chk_bit15_zero: assert property (
		evt_out[15] == 1'b0 && cond_out[15] == 1'b0 && (evt_out & ~VALID_MASK) == 16'h0000)
		else $error("unused or bit 15 event bit set");
	chk_evt_holds: assert property (
		s_evt_kept |=> (evt_out & $past(evt_out)) == $past(evt_out))
		else $error("event bit lost before read");

endmodule
`default_nettype wire

// >>> hw/ises_status_regs.sv
// status reporting bank: standard event latch and mask, operation, questionable registers
`timescale 1ns/100ps
`default_nettype none
`include "ises_consts.svh"

// Function
// - set latch bit 0 once all previously issued operations have completed
// - set bit 2 on read without query or on abandoned response
// - device fault sets bit 3 and queues code -300..-399 or positive unless a command or execution error comes in the same cycle
// - unexecutable well-formed command sets bit 4, queues code -200..-299 unless a command error comes in the same cycle
// - unknown or malformed command sets bit 5, queues code -100..-199
// - bit 7 of the latch is set at switch-on
// - 8-bit enable mask beside the latch, writable and readable
// - latch readable as bit pattern, behaves like an event part
// - operation condition part shows actions in progress
// - operation event part collects completed actions since last read
// - operation bits 0..14 unused read zero; bit 15 always zero
// - questionable bit 3 set when a channel power level is questionable
// - questionable bit 5 set on oscillator or reference frequency fault
// - questionable bit 9 on limit violation; others below 15 stay zero
// - questionable condition and event parts readable separately
// - frequency register bit 8 while external reference used; rest zero
// - status byte bit 5 high when any enabled latch bit is set
// - status byte bit 3 high when any enabled questionable event set
module ises_status_regs
	import ises_pkg::*;
(
	input  wire logic      ref_clk,
	input  wire logic      sys_rst,
	input  wire ises_cmd_s cmd,
	input  wire ises_src_s src,
	output ises_rsp_s      rsp,
	output ises_err_s      err,
	output ises_sum_s      stb_sum
);

	ises_state_s st_q;
	ises_state_s st_d;

	logic [15:0] oper_cond;
	logic [15:0] oper_evt;
	logic [15:0] oper_ena;
	logic        oper_sum;
	logic [15:0] ques_cond;
	logic [15:0] ques_evt;
	logic [15:0] ques_ena;
	logic        ques_sum;
	logic [15:0] qfrq_cond;
	logic [15:0] qfrq_evt;
	logic [15:0] qfrq_ena;
	logic        qfrq_sum;
	logic [15:0] ques_src;
	logic [15:0] qfrq_src;
	logic        rd_take;
	logic        wr_take;
	logic        qerr;
	logic [7:0]  lat_set;

	// signed range test, used for each error class
	function automatic logic in_range(input logic [15:0] c, input logic [15:0] lo,
		input logic [15:0] hi);
		in_range = ($signed(c) >= $signed(lo)) && ($signed(c) <= $signed(hi));
	endfunction

	// a read or write is accepted every cycle, no back-pressure
	assign rd_take = cmd.valid & ~cmd.write;
	assign wr_take = cmd.valid & cmd.write;

	// questionable sources; frequency summary folds into the frequency bit
	always_comb begin
		ques_src                   = 16'h0000;
		ques_src[`ISES_QUES_POWER] = src.power_bad;
		ques_src[`ISES_QUES_FREQ]  = src.freq_bad | qfrq_sum;
		ques_src[`ISES_QUES_LIMIT] = src.limit_fail;
		qfrq_src                     = 16'h0000;
		qfrq_src[`ISES_QFREQ_EXTREF] = src.ext_ref;
	end

	// no operation actions are assigned, so its condition stays clear
	ises_evreg #(.VALID_MASK(`ISES_OPER_MASK)) u_oper (
		.ref_clk   (ref_clk),
		.sys_rst   (sys_rst),
		.cond_in   (16'h0000),
		.evt_clr   (rd_take && cmd.sel == ISES_SEL_OPER_EVT),
		.ena_we    (wr_take && cmd.sel == ISES_SEL_OPER_ENA),
		.ena_wdata (cmd.wdata),
		.cond_out  (oper_cond),
		.evt_out   (oper_evt),
		.ena_out   (oper_ena),
		.summary   (oper_sum)
	);

	ises_evreg #(.VALID_MASK(`ISES_QUES_MASK)) u_ques (
		.ref_clk   (ref_clk),
		.sys_rst   (sys_rst),
		.cond_in   (ques_src),
		.evt_clr   (rd_take && cmd.sel == ISES_SEL_QUES_EVT),
		.ena_we    (wr_take && cmd.sel == ISES_SEL_QUES_ENA),
		.ena_wdata (cmd.wdata),
		.cond_out  (ques_cond),
		.evt_out   (ques_evt),
		.ena_out   (ques_ena),
		.summary   (ques_sum)
	);

	ises_evreg #(.VALID_MASK(`ISES_QFREQ_MASK)) u_qfrq (
		.ref_clk   (ref_clk),
		.sys_rst   (sys_rst),
		.cond_in   (qfrq_src),
		.evt_clr   (rd_take && cmd.sel == ISES_SEL_QFRQ_EVT),
		.ena_we    (wr_take && cmd.sel == ISES_SEL_QFRQ_ENA),
		.ena_wdata (cmd.wdata),
		.cond_out  (qfrq_cond),
		.evt_out   (qfrq_evt),
		.ena_out   (qfrq_ena),
		.summary   (qfrq_sum)
	);

	// query error: read with nothing pending, or new command abandons a response
	assign qerr = (src.resp_read & ~st_q.resp_pend) | (src.new_cmd & st_q.resp_pend);

	// latch set sources for this cycle
	always_comb begin
		lat_set                      = 8'h00;
		lat_set[`ISES_LAT_OPC]       = st_q.opc_wait & ~src.ops_busy;
		lat_set[`ISES_LAT_QUERY_ERR] = qerr;
		lat_set[`ISES_LAT_DEV_ERR]   = src.dev_err;
		lat_set[`ISES_LAT_EXEC_ERR]  = src.exec_err;
		lat_set[`ISES_LAT_CMD_ERR]   = src.cmd_err;
	end

	// next state: latch, mask, pending flags, response and error push
	always_comb begin
		st_d = st_q;
		// set wins over the read-clear in the same cycle
		st_d.lat = (rd_take && cmd.sel == ISES_SEL_LAT) ? lat_set : (st_q.lat | lat_set);
		if (wr_take && cmd.sel == ISES_SEL_MSK) begin
			st_d.msk = cmd.wdata[7:0];
		end
		// opc waits for the busy flag to drop; a new request re-arms it
		if (src.opc_req) begin
			st_d.opc_wait = 1'b1;
		end else if (lat_set[`ISES_LAT_OPC]) begin
			st_d.opc_wait = 1'b0;
		end
		// pending response tracking, dropped when abandoned or fetched
		if (src.query_sent) begin
			st_d.resp_pend = 1'b1;
		end else if (src.resp_read | src.new_cmd) begin
			st_d.resp_pend = 1'b0;
		end
		// read answer one cycle after the request
		st_d.rsp.valid = rd_take;
		if (rd_take) begin
			case (cmd.sel)
				ISES_SEL_LAT:       st_d.rsp.data = {8'h00, st_q.lat};
				ISES_SEL_MSK:       st_d.rsp.data = {8'h00, st_q.msk};
				ISES_SEL_OPER_COND: st_d.rsp.data = oper_cond;
				ISES_SEL_OPER_EVT:  st_d.rsp.data = oper_evt;
				ISES_SEL_OPER_ENA:  st_d.rsp.data = oper_ena;
				ISES_SEL_QUES_COND: st_d.rsp.data = ques_cond;
				ISES_SEL_QUES_EVT:  st_d.rsp.data = ques_evt;
				ISES_SEL_QUES_ENA:  st_d.rsp.data = ques_ena;
				ISES_SEL_QFRQ_COND: st_d.rsp.data = qfrq_cond;
				ISES_SEL_QFRQ_EVT:  st_d.rsp.data = qfrq_evt;
				ISES_SEL_QFRQ_ENA:  st_d.rsp.data = qfrq_ena;
				default:            st_d.rsp.data = 16'h0000;
			endcase
		end
		// one queue entry per cycle: command, then execution, then device class;
		// a detail outside its class range falls back to the class's first code
		st_d.err.push = src.cmd_err | src.exec_err | src.dev_err;
		if (src.cmd_err) begin
			st_d.err.code = in_range(src.err_detail, `ISES_CMD_LO, `ISES_CMD_HI) ?
				src.err_detail : `ISES_CMD_HI;
		end else if (src.exec_err) begin
			st_d.err.code = in_range(src.err_detail, `ISES_EXEC_LO, `ISES_EXEC_HI) ?
				src.err_detail : `ISES_EXEC_HI;
		end else if (src.dev_err) begin
			st_d.err.code = (in_range(src.err_detail, `ISES_DEV_LO, `ISES_DEV_HI) ||
				$signed(src.err_detail) > 0) ? src.err_detail : `ISES_DEV_HI;
		end else begin
			st_d.err.code = 16'h0000;
		end
	end

	// power-on leaves the switch-on bit standing in the latch
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			st_q <= '{lat: `ISES_LAT_RST, msk: `ISES_MSK_RST, opc_wait: 1'b0,
				resp_pend: 1'b0, rsp: '{valid: 1'b0, data: 16'h0000},
				err: '{push: 1'b0, code: 16'h0000}};
		end else begin
			st_q <= st_d;
		end
	end

	assign rsp = st_q.rsp;
	assign err = st_q.err;

	// status byte summaries, combinational from registered parts
	assign stb_sum.esb      = |(st_q.lat & st_q.msk);
	assign stb_sum.ques_sum = ques_sum;
	assign stb_sum.oper_sum = oper_sum;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	// completion armed while operations are still outstanding
	sequence s_opc_armed;
		st_q.opc_wait && src.ops_busy;
	endsequence

	// busy has dropped and no fresh request came with it
	sequence s_opc_done;
		!src.ops_busy && !src.opc_req;
	endsequence

	// a response is pending and the controller moves on without it
	sequence s_resp_dropped;
		st_q.resp_pend && src.new_cmd && !src.query_sent;
	endsequence

	// operation complete
	chk_opc_after_busy: assert property (
		s_opc_armed ##1 s_opc_done |=> st_q.lat[`ISES_LAT_OPC])
		else $error("operation complete not set after busy dropped");
	chk_opc_held_back: assert property (
		!st_q.opc_wait |=> !st_q.lat[`ISES_LAT_OPC] || $past(st_q.lat[`ISES_LAT_OPC]))
		else $error("operation complete set with nothing outstanding");
	// query errors
	chk_query_err_set: assert property (
		s_resp_dropped |=> st_q.lat[`ISES_LAT_QUERY_ERR])
		else $error("abandoned response did not flag query error");
	chk_query_err_read: assert property (
		src.resp_read && !st_q.resp_pend |=> st_q.lat[`ISES_LAT_QUERY_ERR])
		else $error("read without query did not flag query error");
	chk_query_ok_read: assert property (
		src.resp_read && st_q.resp_pend && !src.new_cmd && !st_q.lat[`ISES_LAT_QUERY_ERR]
		|=> !st_q.lat[`ISES_LAT_QUERY_ERR])
		else $error("fetched response flagged as query error");
	// error classes and their queue entries
	chk_dev_err_code: assert property (
		src.dev_err && !src.cmd_err && !src.exec_err |=> err.push &&
		(in_range(err.code, `ISES_DEV_LO, `ISES_DEV_HI) || $signed(err.code) > 0) &&
		st_q.lat[`ISES_LAT_DEV_ERR])
		else $error("device error entry wrong");
	chk_exec_err_code: assert property (
		src.exec_err && !src.cmd_err |=> err.push &&
		in_range(err.code, `ISES_EXEC_LO, `ISES_EXEC_HI) && st_q.lat[`ISES_LAT_EXEC_ERR])
		else $error("execution error entry wrong");
	chk_cmd_err_code: assert property (
		src.cmd_err |=> err.push && in_range(err.code, `ISES_CMD_LO, `ISES_CMD_HI) &&
		st_q.lat[`ISES_LAT_CMD_ERR])
		else $error("command error entry wrong");
	chk_err_idle: assert property (
		!src.cmd_err && !src.exec_err && !src.dev_err |=> !err.push && err.code == 16'h0000)
		else $error("error entry queued without a fault");
	// switch-on, mask and latch access
	chk_power_on_bit: assert property (
		$past(sys_rst) |-> st_q.lat[`ISES_LAT_PWR_ON])
		else $error("switch-on bit missing after reset");
	chk_mask_write: assert property (
		wr_take && cmd.sel == ISES_SEL_MSK |=> st_q.msk == $past(cmd.wdata[7:0]))
		else $error("enable mask write lost");
	chk_mask_read: assert property (
		rd_take && cmd.sel == ISES_SEL_MSK |=> rsp.valid && rsp.data == {8'h00, $past(st_q.msk)})
		else $error("enable mask readback mismatch");
	chk_lat_read_clr: assert property (
		rd_take && cmd.sel == ISES_SEL_LAT && lat_set == 8'h00
		|=> rsp.data == {8'h00, $past(st_q.lat)} && st_q.lat == 8'h00)
		else $error("latch read did not return and clear");
	chk_lat_set_wins: assert property (
		rd_take && cmd.sel == ISES_SEL_LAT && src.cmd_err |=> st_q.lat[`ISES_LAT_CMD_ERR])
		else $error("latch event lost in clearing read");
	chk_rsp_after_read: assert property (
		rd_take |=> rsp.valid)
		else $error("read not answered");
	chk_rsp_pulse: assert property (
		!rd_take |=> !rsp.valid)
		else $error("answer without a read");
	// summaries and register contents
	chk_oper_silent: assert property (
		oper_cond == 16'h0000 && oper_evt == 16'h0000 && !stb_sum.oper_sum)
		else $error("operation register shows a bit");
	chk_esb_summary: assert property (
		stb_sum.esb == ((st_q.lat & st_q.msk) != 8'h00))
		else $error("event summary bit wrong");
	chk_power_cond: assert property (
		ques_cond[`ISES_QUES_POWER] == src.power_bad)
		else $error("power condition bit wrong");
	chk_freq_cond: assert property (
		ques_cond[`ISES_QUES_FREQ] == (src.freq_bad || qfrq_sum))
		else $error("frequency condition bit wrong");
	chk_ques_unused: assert property (
		ques_cond[15:10] == 6'h00 && ques_cond[8:6] == 3'h0 && ques_cond[4] == 1'b0 &&
		ques_cond[2:0] == 3'h0)
		else $error("unassigned questionable bit set");
	chk_ques_summary: assert property (
		stb_sum.ques_sum == ((ques_evt & ques_ena) != 16'h0000))
		else $error("questionable summary bit wrong");
	chk_limit_event: assert property (
		!src.limit_fail ##1 src.limit_fail |=> ques_evt[`ISES_QUES_LIMIT])
		else $error("limit event not latched");
	chk_extref_cond: assert property (
		qfrq_cond == (src.ext_ref ? 16'h0100 : 16'h0000))
		else $error("frequency condition wrong");

endmodule
`default_nettype wire

// >>> dv/ises_host_model.sv
// remote controller model issuing status queries and writes
`timescale 1ns/100ps
`default_nettype none

module ises_host_model
	import ises_pkg::*;
(
	input  wire logic      ref_clk,
	output var  ises_cmd_s cmd,
	input  wire ises_rsp_s rsp
);
	// idle command word
	initial cmd = '0;

	// one-cycle write strobe, no answer comes back
	task automatic wr(input ises_sel_e s, input logic [15:0] w);
		@(posedge ref_clk);
		#1 cmd = '{valid: 1'b1, write: 1'b1, sel: s, wdata: w};
		@(posedge ref_clk);
		// stale data flipped so a late sample cannot pass
		#1 cmd = '{valid: 1'b0, write: 1'b1, sel: s, wdata: ~w};
	endtask

	// query, then a bounded wait for the answer pulse
	task automatic rd(input ises_sel_e s, output logic [15:0] d);
		int n;
		@(posedge ref_clk);
		#1 cmd = '{valid: 1'b1, write: 1'b0, sel: s, wdata: ~cmd.wdata};
		@(posedge ref_clk);
		#1 cmd.valid = 1'b0;
		n = 0;
		while (rsp.valid !== 1'b1 && n < 3) begin
			@(posedge ref_clk);
			#1 n++;
		end
		// no answer gives unknown data, which fails any compare
		d = (rsp.valid === 1'b1) ? rsp.data : 16'hxxxx;
	endtask
endmodule

`default_nettype wire

// >>> dv/test_ises_status_regs.sv
// self-checking bench for the status and event register bank
`timescale 1ns/100ps
`default_nettype none

module test_ises_status_regs
	import ises_pkg::*;
;
	localparam logic [7:0] P_CMD  = 8'h01;
	localparam logic [7:0] P_NEW  = 8'h08;
	localparam logic [7:0] P_READ = 8'h10;
	localparam logic [7:0] P_QRY  = 8'h20;
	localparam logic [7:0] P_OPC  = 8'h80;

	logic        ref_clk;
	logic        sys_rst;
	ises_cmd_s   cmd;
	ises_src_s   src;
	ises_rsp_s   rsp;
	ises_err_s   err;
	ises_sum_s   stb_sum;
	logic [15:0] d;
	int          n_fail = 0;
	int          comparisons = 0;
	int          cycles = 0;

	// error rows: pulses, detail, queued code, latch after
	logic [47:0] rows [8] = '{
		{8'h01, 16'hff97, 16'hff97, 8'h20},
		{8'h01, 16'hff06, 16'hff9c, 8'h20},
		{8'h02, 16'hff22, 16'hff22, 8'h10},
		{8'h02, 16'h0005, 16'hff38, 8'h10},
		{8'h04, 16'hfea2, 16'hfea2, 8'h08},
		{8'h04, 16'h0005, 16'h0005, 8'h08},
		{8'h04, 16'hff6a, 16'hfed4, 8'h08},
		{8'h07, 16'hff97, 16'hff97, 8'h38}
	};

	ises_status_regs i_dut (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.cmd     (cmd),
		.src     (src),
		.rsp     (rsp),
		.err     (err),
		.stb_sum (stb_sum)
	);

	ises_host_model i_host (
		.ref_clk (ref_clk),
		.cmd     (cmd),
		.rsp     (rsp)
	);

	// 20 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	task automatic give_verdict();
		$display("comparisons %0d, mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		comparisons++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected at %0t: got %h, expected %h", $time, g, e);
		end
	endtask

	// one-cycle source pulses on the top byte of the source word
	task automatic pulse(input logic [7:0] p);
		@(posedge ref_clk);
		#1 src[27:20] = src[27:20] | p;
		@(posedge ref_clk);
		#1 src[27:20] = src[27:20] & ~p;
	endtask

	// hang guard, run needs about 120 cycles
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 2000) begin
			n_fail++;
			give_verdict();
		end
	end

	initial begin
		sys_rst = 1'b1;
		src = '0;
		repeat (8) @(posedge ref_clk);
		#1 sys_rst = 1'b0;
		// switch-on bit shows once, then the read clears it
		i_host.rd(ISES_SEL_LAT, d);
		chk(d, 16'h0080);
		i_host.rd(ISES_SEL_LAT, d);
		chk(d, 16'h0000);
		i_host.rd(ISES_SEL_MSK, d);
		chk(d, 16'h0000);
		// error classes, out-of-range details and a three-way collision
		for (int i = 0; i < 8; i++) begin
			src.err_detail = rows[i][39:24];
			pulse(rows[i][47:40]);
			chk({15'h0000, err.push}, 16'h0001);
			chk(err.code, rows[i][23:8]);
			i_host.rd(ISES_SEL_LAT, d);
			chk(d, {8'h00, rows[i][7:0]});
		end
		// summary only when latch bit and mask bit meet
		i_host.wr(ISES_SEL_MSK, 16'h0010);
		pulse(P_CMD);
		chk({15'h0000, stb_sum.esb}, 16'h0000);
		i_host.wr(ISES_SEL_MSK, 16'hff20);
		i_host.rd(ISES_SEL_MSK, d);
		chk(d, 16'h0020);
		chk({15'h0000, stb_sum.esb}, 16'h0001);
		i_host.rd(ISES_SEL_LAT, d);
		chk(d, 16'h0020);
		chk({15'h0000, stb_sum.esb}, 16'h0000);
		// completion held back while operations are outstanding
		src.ops_busy = 1'b1;
		pulse(P_OPC);
		i_host.rd(ISES_SEL_OPER_COND, d);
		chk(d, 16'h0000);
		i_host.rd(ISES_SEL_LAT, d);
		chk(d, 16'h0000);
		src.ops_busy = 1'b0;
		repeat (2) @(posedge ref_clk);
		#1;
		i_host.rd(ISES_SEL_LAT, d);
		chk(d, 16'h0001);
		i_host.rd(ISES_SEL_OPER_EVT, d);
		chk(d, 16'h0000);
		// operation register stays silent even fully enabled
		i_host.wr(ISES_SEL_OPER_ENA, 16'hffff);
		i_host.rd(ISES_SEL_OPER_ENA, d);
		chk(d, 16'h7fff);
		chk({15'h0000, stb_sum.oper_sum}, 16'h0000);
		// read without query, proper reply, abandoned reply
		pulse(P_READ);
		i_host.rd(ISES_SEL_LAT, d);
		chk(d, 16'h0004);
		pulse(P_QRY);
		pulse(P_READ);
		i_host.rd(ISES_SEL_LAT, d);
		chk(d, 16'h0000);
		pulse(P_QRY);
		pulse(P_NEW);
		i_host.rd(ISES_SEL_LAT, d);
		chk(d, 16'h0004);
		// questionable sources, enable with bit 15 forced low
		src.power_bad = 1'b1;
		src.freq_bad = 1'b1;
		src.limit_fail = 1'b1;
		i_host.rd(ISES_SEL_QUES_COND, d);
		chk(d, 16'h0228);
		chk({15'h0000, stb_sum.ques_sum}, 16'h0000);
		i_host.wr(ISES_SEL_QUES_ENA, 16'hffff);
		i_host.rd(ISES_SEL_QUES_ENA, d);
		chk(d, 16'h7fff);
		chk({15'h0000, stb_sum.ques_sum}, 16'h0001);
		i_host.rd(ISES_SEL_QUES_EVT, d);
		chk(d, 16'h0228);
		i_host.rd(ISES_SEL_QUES_EVT, d);
		chk(d, 16'h0000);
		chk({15'h0000, stb_sum.ques_sum}, 16'h0000);
		src.power_bad = 1'b0;
		src.freq_bad = 1'b0;
		src.limit_fail = 1'b0;
		i_host.rd(ISES_SEL_QUES_COND, d);
		chk(d, 16'h0000);
		// a fresh rise after a low spell latches again
		src.power_bad = 1'b1;
		i_host.rd(ISES_SEL_QUES_EVT, d);
		chk(d, 16'h0008);
		// external reference in the frequency register
		src.ext_ref = 1'b1;
		i_host.rd(ISES_SEL_QFRQ_COND, d);
		chk(d, 16'h0100);
		i_host.rd(ISES_SEL_QFRQ_EVT, d);
		chk(d, 16'h0100);
		// an error in the clearing read's own cycle survives the read
		fork
			pulse(P_CMD);
			i_host.rd(ISES_SEL_LAT, d);
		join
		chk(d, 16'h0000);
		chk({15'h0000, stb_sum.esb}, 16'h0001);
		i_host.rd(ISES_SEL_LAT, d);
		chk(d, 16'h0020);
		i_host.rd(ises_sel_e'(4'hf), d);
		chk(d, 16'h0000);
		// second reset mid-run restores switch-on state
		i_host.wr(ISES_SEL_MSK, 16'h00ff);
		sys_rst = 1'b1;
		repeat (2) @(posedge ref_clk);
		#1 sys_rst = 1'b0;
		i_host.rd(ISES_SEL_LAT, d);
		chk(d, 16'h0080);
		i_host.rd(ISES_SEL_MSK, d);
		chk(d, 16'h0000);
		i_host.rd(ISES_SEL_QUES_ENA, d);
		chk(d, 16'h0000);
		give_verdict();
	end
endmodule

`default_nettype wire
